// File: ioc_pkg.sv
// Shared constants for the io cell: register offsets, field positions, reset values.
// Assumes a 32-bit classic Wishbone register bus with byte addressing.
package ioc_pkg;

	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam logic [7:0]  CTRL_ADDR    = 8'h00;
	localparam logic [7:0]  STATUS_ADDR  = 8'h04;

	// ------------------------------------------------------------
	// Control field positions
	// ------------------------------------------------------------
	localparam int          CTRL_START   = 0;
	localparam int          CTRL_INV_IK  = 1;
	localparam int          CTRL_INV_OK  = 2;
	localparam int          CTRL_INV_O   = 3;
	localparam int          CTRL_INV_T   = 4;
	localparam int          CTRL_CAP_EN  = 5;
	localparam int          CTRL_IN_LAT  = 6;
	localparam int          CTRL_OREG_EN = 7;
	localparam int          CTRL_TREG_EN = 8;
	localparam int          CTRL_FAST    = 9;
	localparam int          CTRL_INIT_IN = 10;
	localparam int          CTRL_INIT_O  = 11;
	localparam int          CTRL_CE_IN   = 12;
	localparam int          CTRL_CE_OUT  = 13;
	localparam int          CTRL_INV_A   = 14;
	localparam int          CTRL_INV_B   = 15;
	localparam int          CTRL_FN_LSB  = 16;

	// ------------------------------------------------------------
	// Reset and mask values
	// ------------------------------------------------------------
	localparam logic [31:0] CTRL_RESET   = 32'h0000_3000;
	localparam logic [31:0] CTRL_WMASK   = 32'h0007_ffff;
	localparam logic        TREG_RESET   = 1'h1;

	// ------------------------------------------------------------
	// Output gate functions
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		FN_PASS = 3'h0,
		FN_MUX  = 3'h1,
		FN_AND  = 3'h2,
		FN_OR   = 3'h3,
		FN_XOR  = 3'h4
	} ioc_fn_t;

endpackage

// File: ioc_clk_sense.sv
// Samples one cell clock, applies its optional inversion, marks rising edges.
// Assumes the cell clock is synchronous to clk and slower than it.
`timescale 1ns/1ps
module ioc_clk_sense (
	input  wire logic clk,
	input  wire logic srst,
	input  wire logic clk_in,
	input  wire logic invert,
	output logic      level,
	output logic      rise
);

	logic prev;
	logic next_level;
	logic next_prev;

	// ------------------------------------------------------------
	// Inversion and edge detection
	// ------------------------------------------------------------
	always_comb begin
		next_level = clk_in ^ invert;
		next_prev  = level;
	end

	// Register sampled level and its previous value
	// Both follow the pin in reset, so a high pin gives no false edge after it
	always_ff @(posedge clk) begin
		if (srst) begin
			level <= next_level;
			prev  <= next_level;
		end else begin
			level <= next_level;
			prev  <= next_prev;
		end
	end

	assign rise = level & ~prev;

endmodule

// File: ioc_top.sv
// One io cell: fast-capture input path, output gate and register, three-state control.
// Assumes classic Wishbone on CLK; cell clocks and pad are synchronous samples on CLK.
//
// Register access over Wishbone and the register addresses were left to the implementer.
`timescale 1ns/1ps
module ioc_top (
	input  wire logic        CLK,
	input  wire logic        SRST,
	input  wire logic [7:0]  WB_ADR_I,
	input  wire logic [31:0] WB_DAT_I,
	input  wire logic        WB_WE_I,
	input  wire logic [3:0]  WB_SEL_I,
	input  wire logic        WB_STB_I,
	input  wire logic        WB_CYC_I,
	output logic      [31:0] WB_DAT_O,
	output logic             WB_ACK_O,
	input  wire logic        GLOBAL_SET_RESET,
	input  wire logic        SHARED_CLOCK_ENABLE,
	input  wire logic        IN_CLK,
	input  wire logic        OUT_CLK,
	input  wire logic        OUT_DATA,
	input  wire logic        OUT_DATA_B,
	input  wire logic        TRI_CTRL,
	input  wire logic        PAD_IN,
	output logic             PAD_OUT,
	output logic             PAD_OE,
	output logic             PAD_FAST,
	output logic             FAB_IN_DIRECT,
	output logic             FAB_IN_REG
);

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	logic [31:0] ctrl;
	logic [31:0] next_ctrl;
	logic        next_ack;
	logic [31:0] next_rdata;
	logic        req;
	logic        cap;
	logic        next_cap;
	logic        in_reg;
	logic        next_in_reg;
	logic        out_reg;
	logic        next_out_reg;
	logic        tri_reg;
	logic        next_tri_reg;
	logic        soft_done;
	logic        next_soft_done;
	logic        next_pad_out;
	logic        next_pad_oe;
	logic        next_pad_fast;
	logic        ik_lvl;
	logic        ik_rise;
	logic        ok_lvl;
	logic        ok_rise;
	logic        started;
	logic        ce_in;
	logic        ce_out;
	logic        in_src;
	logic        gate_out;
	logic        o_val;
	logic        t_val;
	logic        d_eff;
	logic        t_eff;
	ioc_pkg::ioc_fn_t fn;

	// Expand byte selects into a bit mask
	function automatic logic [31:0] lane_mask(input logic [3:0] sel);
		logic [31:0] m;
		m = 32'h0;
		for (int i = 0; i < 4; i++) begin
			m[i*8 +: 8] = {8{sel[i]}};
		end
		return m;
	endfunction

	// ------------------------------------------------------------
	// Configuration fields
	// ------------------------------------------------------------
	assign started = ctrl[ioc_pkg::CTRL_START];
	assign fn      = ioc_pkg::ioc_fn_t'(ctrl[ioc_pkg::CTRL_FN_LSB +: 3]);
	assign req     = WB_CYC_I & WB_STB_I;

	// ------------------------------------------------------------
	// Cell clock sensing
	// ------------------------------------------------------------
	// Input clock with its own inversion
	ioc_clk_sense u_ik (
		.clk    (CLK),
		.srst   (SRST),
		.clk_in (IN_CLK),
		.invert (ctrl[ioc_pkg::CTRL_INV_IK]),
		.level  (ik_lvl),
		.rise   (ik_rise)
	);

	// Output clock with its own inversion
	ioc_clk_sense u_ok (
		.clk    (CLK),
		.srst   (SRST),
		.clk_in (OUT_CLK),
		.invert (ctrl[ioc_pkg::CTRL_INV_OK]),
		.level  (ok_lvl),
		.rise   (ok_rise)
	);

	// ------------------------------------------------------------
	// Wishbone slave and configuration register
	// ------------------------------------------------------------
	// Ack one cycle after request, write on the acked edge
	always_comb begin
		logic [31:0] m;
		m          = 32'h0;
		next_ack   = req & ~WB_ACK_O;
		next_rdata = WB_DAT_O;
		next_ctrl  = ctrl;
		if (req && !WB_ACK_O) begin
			unique case (WB_ADR_I)
				ioc_pkg::CTRL_ADDR:   next_rdata = ctrl;
				ioc_pkg::STATUS_ADDR: next_rdata = {25'h0, started, soft_done, tri_reg,
					out_reg, in_reg, cap, PAD_IN};
				default:              next_rdata = 32'h0;
			endcase
		end
		if (req && WB_ACK_O && WB_WE_I && WB_ADR_I == ioc_pkg::CTRL_ADDR) begin
			m = lane_mask(WB_SEL_I) & ioc_pkg::CTRL_WMASK;
			if (started) begin
				m = m & (32'h1 << ioc_pkg::CTRL_START);
			end
			next_ctrl = (ctrl & ~m) | (WB_DAT_I & m);
			next_ctrl[ioc_pkg::CTRL_START] = ctrl[ioc_pkg::CTRL_START] |
				next_ctrl[ioc_pkg::CTRL_START];
		end
	end

	// Register bus state
	always_ff @(posedge CLK) begin
		if (SRST) begin
			ctrl     <= ioc_pkg::CTRL_RESET;
			WB_ACK_O <= 1'h0;
			WB_DAT_O <= 32'h0;
		end else begin
			ctrl     <= next_ctrl;
			WB_ACK_O <= next_ack;
			WB_DAT_O <= next_rdata;
		end
	end

	// ------------------------------------------------------------
	// Output gate, polarity and enables
	// ------------------------------------------------------------
	// Gate or mux ahead of the output register
	always_comb begin
		logic fa;
		logic fb;
		fa = ok_lvl ^ ctrl[ioc_pkg::CTRL_INV_A];
		fb = OUT_DATA ^ ctrl[ioc_pkg::CTRL_INV_B];
		unique case (fn)
			ioc_pkg::FN_MUX:  gate_out = ok_lvl ? OUT_DATA_B : OUT_DATA;
			ioc_pkg::FN_AND:  gate_out = fa & fb;
			ioc_pkg::FN_OR:   gate_out = fa | fb;
			ioc_pkg::FN_XOR:  gate_out = fa ^ fb;
			ioc_pkg::FN_PASS: gate_out = fb;
			default:          gate_out = fb;           // Spare codes pass
		endcase
		o_val  = gate_out ^ ctrl[ioc_pkg::CTRL_INV_O];
		t_val  = TRI_CTRL ^ ctrl[ioc_pkg::CTRL_INV_T];
		ce_in  = ~ctrl[ioc_pkg::CTRL_CE_IN] | SHARED_CLOCK_ENABLE;
		ce_out = ~ctrl[ioc_pkg::CTRL_CE_OUT] | SHARED_CLOCK_ENABLE;
		in_src = ctrl[ioc_pkg::CTRL_CAP_EN] ? cap : PAD_IN;
	end

	// ------------------------------------------------------------
	// Cell storage and pad drive
	// ------------------------------------------------------------
	// Next values of capture, input, output and three-state stages
	always_comb begin
		next_cap     = cap;
		next_in_reg  = in_reg;
		next_out_reg = out_reg;
		next_tri_reg = tri_reg;
		if (ctrl[ioc_pkg::CTRL_CAP_EN] && !ok_lvl) begin
			next_cap = PAD_IN;
		end
		if (ctrl[ioc_pkg::CTRL_IN_LAT]) begin
			if (ik_lvl && ce_in) begin
				next_in_reg = in_src;
			end
		end else if (ik_rise && ce_in) begin
			next_in_reg = in_src;
		end
		if (ok_rise && ce_out) begin
			next_out_reg = o_val;
			next_tri_reg = t_val;
		end
		if (GLOBAL_SET_RESET) begin
			next_in_reg  = ctrl[ioc_pkg::CTRL_INIT_IN];
			next_out_reg = ctrl[ioc_pkg::CTRL_INIT_O];
			next_tri_reg = ioc_pkg::TREG_RESET;
		end
		d_eff = ctrl[ioc_pkg::CTRL_OREG_EN] ? out_reg : o_val;
		t_eff = ctrl[ioc_pkg::CTRL_TREG_EN] ? tri_reg : t_val;
		next_pad_out   = d_eff;
		next_pad_oe    = started & ~t_eff;
		next_soft_done = soft_done | PAD_OE;
		next_pad_fast  = soft_done & ctrl[ioc_pkg::CTRL_FAST];
	end

	// Register cell state and pad outputs
	always_ff @(posedge CLK) begin
		if (SRST) begin
			cap           <= 1'h0;
			in_reg        <= 1'h0;
			out_reg       <= 1'h0;
			tri_reg       <= ioc_pkg::TREG_RESET;
			soft_done     <= 1'h0;
			PAD_OUT       <= 1'h0;
			PAD_OE        <= 1'h0;
			PAD_FAST      <= 1'h0;
			FAB_IN_DIRECT <= 1'h0;
			FAB_IN_REG    <= 1'h0;
		end else begin
			cap           <= next_cap;
			in_reg        <= next_in_reg;
			out_reg       <= next_out_reg;
			tri_reg       <= next_tri_reg;
			soft_done     <= next_soft_done;
			PAD_OUT       <= next_pad_out;
			PAD_OE        <= next_pad_oe;
			PAD_FAST      <= next_pad_fast;
			FAB_IN_DIRECT <= PAD_IN;
			FAB_IN_REG    <= in_reg;
		end
	end

endmodule

// File: ioc_chk.sv
// Checker of io cell port relations, with a shadow copy of the control word.
// Assumes a bind onto ioc_top and classic Wishbone on CLK.
`timescale 1ns/1ps
module ioc_chk (
	input wire logic        CLK,
	input wire logic        SRST,
	input wire logic [7:0]  WB_ADR_I,
	input wire logic [31:0] WB_DAT_I,
	input wire logic        WB_WE_I,
	input wire logic [3:0]  WB_SEL_I,
	input wire logic        WB_STB_I,
	input wire logic        WB_CYC_I,
	input wire logic        WB_ACK_O,
	input wire logic        GLOBAL_SET_RESET,
	input wire logic        OUT_CLK,
	input wire logic        TRI_CTRL,
	input wire logic        PAD_OUT,
	input wire logic        PAD_OE,
	input wire logic        PAD_FAST
);
	logic [31:0] sh, next_sh, m;
	logic        seen, next_seen;
	// ----
	// Shadow state
	// ----
	// Control copy, frozen once started; flag for first pad drive
	always_comb begin
		m = {{8{WB_SEL_I[3]}}, {8{WB_SEL_I[2]}}, {8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};
		next_seen = !SRST && (seen || PAD_OE);
		if (SRST)
			next_sh = ioc_pkg::CTRL_RESET;
		else if (WB_ACK_O && WB_CYC_I && WB_STB_I && WB_WE_I &&
			WB_ADR_I == ioc_pkg::CTRL_ADDR && !sh[0])
			next_sh = (sh & ~(m & ioc_pkg::CTRL_WMASK)) | (WB_DAT_I & m & ioc_pkg::CTRL_WMASK);
		else
			next_sh = sh;
	end
	always_ff @(posedge CLK) begin
		sh <= next_sh;
		seen <= next_seen;
	end
	default clocking @(posedge CLK); endclocking
	default disable iff (SRST);
	// Every request is answered on the next edge
	AST_ACK_RESP: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
		else $error("ack missing after request");
	AST_OE_IDLE: assert property (!$past(sh[0]) |-> !PAD_OE)
		else $error("pad driven before start");
	AST_TRI_DIR: assert property ($past(sh[0]) && !$past(sh[8]) |->
		PAD_OE == !($past(TRI_CTRL) ^ $past(sh[4])))
		else $error("direct three-state wrong");
	AST_GSR_O: assert property (GLOBAL_SET_RESET [*2] ##0 (sh[0] && sh[7]) |=>
		PAD_OUT == sh[11])
		else $error("output reg not initialised");
	AST_GSR_T: assert property (GLOBAL_SET_RESET [*2] ##0 (sh[0] && sh[8]) |=>
		!PAD_OE)
		else $error("three-state reg not off");
	AST_HOLD: assert property (
		(sh[0] && sh[7] && !GLOBAL_SET_RESET && $stable(OUT_CLK)) [*5] |=> $stable(PAD_OUT))
		else $error("output reg changed without edge");
	AST_FAST: assert property ($past(sh[0]) && !sh[9] |-> !PAD_FAST)
		else $error("fast slew not configured");
	AST_SOFT: assert property (PAD_FAST |-> $past(seen))
		else $error("first activation not slow");
	AST_SOFT_FIRST: assert property ($rose(PAD_OE) && !seen |-> !PAD_FAST ##1 !PAD_FAST)
		else $error("first pad drive not slow");
endmodule
bind ioc_top ioc_chk ioc_chk_inst (
	.CLK              (CLK),
	.SRST             (SRST),
	.WB_ADR_I         (WB_ADR_I),
	.WB_DAT_I         (WB_DAT_I),
	.WB_WE_I          (WB_WE_I),
	.WB_SEL_I         (WB_SEL_I),
	.WB_STB_I         (WB_STB_I),
	.WB_CYC_I         (WB_CYC_I),
	.WB_ACK_O         (WB_ACK_O),
	.GLOBAL_SET_RESET (GLOBAL_SET_RESET),
	.OUT_CLK          (OUT_CLK),
	.TRI_CTRL         (TRI_CTRL),
	.PAD_OUT          (PAD_OUT),
	.PAD_OE           (PAD_OE),
	.PAD_FAST         (PAD_FAST)
);

// File: ioc_pad_model.sv
// Pad and board model: cell drive, outside source or board pull-up.
// Assumes the bench sets the outside source by non-blocking assignment.
`timescale 1ns/1ps
module ioc_pad_model (
	input  wire logic pad_out,
	input  wire logic pad_oe,
	input  wire logic ext_en,
	input  wire logic ext_val,
	output logic      pad_in
);
	// Released pad with no outside source enabled floats up to the pull-up level
	assign pad_in = pad_oe ? pad_out : (ext_en ? ext_val : 1'h1);
endmodule

// File: ioc_top_tb_top.sv
// Self-checking bench of the io cell: bus, output, gate and capture paths.
// Assumes a 20 MHz clock and the pad model on the far side.
`timescale 1ns/1ps
module ioc_top_tb_top;
	logic        clk, srst, we, stb, cyc, ack, global_set_reset, ce, ik, ok, od, odb, tri_c;
	logic        pad_in, pad_out, pad_oe, pad_fast, fdir, freg, ext_en, ext_val;
	logic [7:0]  adr;
	logic [31:0] dat, dato;
	logic [3:0]  sel;
	int          n_fail, tests_run, cycles;
	ioc_top ioc_top_inst (.CLK(clk), .SRST(srst), .WB_ADR_I(adr), .WB_DAT_I(dat),
		.WB_WE_I(we), .WB_SEL_I(sel), .WB_STB_I(stb), .WB_CYC_I(cyc), .WB_DAT_O(dato),
		.WB_ACK_O(ack), .GLOBAL_SET_RESET(global_set_reset), .SHARED_CLOCK_ENABLE(ce), .IN_CLK(ik),
		.OUT_CLK(ok), .OUT_DATA(od), .OUT_DATA_B(odb), .TRI_CTRL(tri_c), .PAD_IN(pad_in),
		.PAD_OUT(pad_out), .PAD_OE(pad_oe), .PAD_FAST(pad_fast), .FAB_IN_DIRECT(fdir),
		.FAB_IN_REG(freg));
	ioc_pad_model ioc_pad_model_inst (.pad_out(pad_out), .pad_oe(pad_oe), .ext_en(ext_en),
		.ext_val(ext_val), .pad_in(pad_in));
	// ----
	// Shared tasks
	// ----
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic cy(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic rst(input int n);
		srst <= 1'h1;
		cy(n);
		srst <= 1'h0;
		cy(1);
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s, output logic [31:0] q);
		cyc <= 1'h1;
		stb <= 1'h1;
		we <= w;
		adr <= a;
		dat <= d;
		sel <= s;
		do begin
			@(posedge clk);
		end while (ack !== 1'h1);
		q = dato;
		cyc <= 1'h0;
		stb <= 1'h0;
		cy(1);
	endtask
	task automatic cfg(input logic [31:0] v);
		logic [31:0] q;
		rst(3);
		wb(1'h1, ioc_pkg::CTRL_ADDR, v, 4'hf, q);
	endtask
	function automatic logic gfn(input int f, input logic a, input logic g, input logic b);
		case (f)
			1: return g ? b : a;
			2: return a & g;
			3: return a | g;
			4: return a ^ g;
			default: return a;
		endcase
	endfunction
	task automatic summarize();
		$display("checks %0d fails %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// ----
	// Scenarios
	// ----
	task automatic t_regs();
		logic [31:0] q;
		wb(1'h0, ioc_pkg::CTRL_ADDR, 32'h0, 4'hf, q);
		chk(q, ioc_pkg::CTRL_RESET);
		wb(1'h1, 8'h08, 32'hffff_ffff, 4'hf, q);
		wb(1'h0, 8'h08, 32'h0, 4'hf, q);
		chk(q, 32'h0);
		wb(1'h1, ioc_pkg::CTRL_ADDR, 32'h00ff_5a5a, 4'h1, q);
		wb(1'h0, ioc_pkg::CTRL_ADDR, 32'h0, 4'hf, q);
		chk(q, 32'h0000_305a);
		wb(1'h1, ioc_pkg::CTRL_ADDR, 32'h0000_0001, 4'h1, q);
		wb(1'h1, ioc_pkg::CTRL_ADDR, 32'hffff_fffe, 4'hf, q);
		wb(1'h0, ioc_pkg::CTRL_ADDR, 32'h0, 4'hf, q);
		chk(q, 32'h0000_3001);
		wb(1'h0, ioc_pkg::STATUS_ADDR, 32'h0, 4'hf, q);
		chk(q[6], 1'h1);
		$display("t_regs done");
	endtask
	task automatic t_od();
		for (int i = 0; i < 2; i++) begin
			cfg(i[0] ? 32'h0000_3011 : 32'h0000_3001);
			for (int v = 0; v < 2; v++) begin
				tri_c <= v[0];
				cy(4);
				chk(pad_oe, !(v[0] ^ i[0]));
				chk(fdir, v[0] ^ i[0]);
				chk(pad_fast, 1'h0);
			end
		end
		$display("t_od done");
	endtask
	task automatic t_oreg();
		tri_c <= 1'h0;
		cfg(32'h0000_3b81);
		global_set_reset <= 1'h1;
		cy(2);
		global_set_reset <= 1'h0;
		cy(3);
		chk(pad_out, 1'h1);
		chk(pad_oe, 1'h0);
		ok <= 1'h1;
		cy(3);
		ok <= 1'h0;
		cy(3);
		chk(pad_out, 1'h1);
		ce <= 1'h1;
		ok <= 1'h1;
		for (int n = 0; n < 10 && pad_oe !== 1'h1; n++)
			cy(1);
		chk(pad_oe, 1'h1);
		chk(pad_fast, 1'h0);
		chk(pad_out, 1'h0);
		cy(4);
		chk(pad_fast, 1'h1);
		ok <= 1'h0;
		$display("t_oreg done");
	endtask
	task automatic t_gate();
		for (int f = 0; f < 5; f++) begin
			for (int k = 0; k < 8; k++) begin
				if (f == 1 && k[1:0] != 2'h0)
					continue;
				cfg({13'h0, f[2:0], k[0], k[1], 10'h0, k[2], 3'h1} | 32'h0000_3000);
				for (int j = 0; j < 4; j++) begin
					od <= j[0];
					ok <= j[1];
					odb <= !j[0];
					cy(5);
					chk(pad_out, gfn(f, j[0] ^ k[0], j[1] ^ k[1], !j[0]) ^ k[2]);
				end
			end
		end
		od <= 1'h0;
		odb <= 1'h1;
		ok <= 1'h0;
		cfg(32'h0001_3005);
		cy(5);
		chk(pad_out, 1'h1);
		ok <= 1'h1;
		cy(5);
		chk(pad_out, 1'h0);
		$display("t_gate done");
	endtask
	task automatic t_cap();
		for (int i = 0; i < 3; i++) begin
			tri_c <= 1'h1;
			ik <= i[1];
			ok <= 1'h0;
			ext_en <= 1'h1;
			ext_val <= 1'h1;
			cfg(32'h0000_3021 | (i[0] ? 32'h40 : 32'h0) | (i[1] ? 32'h2 : 32'h0));
			cy(4);
			ok <= 1'h1;
			cy(4);
			ext_val <= 1'h0;
			ik <= !i[1];
			cy(4);
			chk(freg, 1'h1);
			ik <= i[1];
			ok <= 1'h0;
			cy(4);
			chk(freg, 1'h1);
			ik <= !i[1];
			cy(4);
			chk(freg, 1'h0);
		end
		$display("t_cap done");
	endtask
	// ----
	// Clock, timeout and main sequence
	// ----
	initial begin
		clk = 1'h0;
		forever #25 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			n_fail++;
			summarize();
		end
	end
	initial begin
		{srst, we, stb, cyc, global_set_reset, ce, ik, ok, od, odb, tri_c, ext_en, ext_val} = 13'h1000;
		{adr, dat, sel} = 44'h0;
		rst(20);
		t_regs();
		t_od();
		t_oreg();
		t_gate();
		t_cap();
		summarize();
	end
endmodule
